// File: design/dbmac_pkg.sv
// Constants, codes and carriers of the dual bank multiply-accumulate unit.
// Assumes a single clock domain and an 8-bit host register port.
package dbmac_pkg;
  localparam int IDX_W = 8;
  localparam int SMP_W = 8;
  localparam int ACC_W = 40;
  localparam int SH_W = 3;
  // Register offsets, low address byte
  localparam logic [7:0] ADDR_X_START = 8'h00;
  localparam logic [7:0] ADDR_X_END = 8'h01;
  localparam logic [7:0] ADDR_X_RELOAD = 8'h02;
  localparam logic [7:0] ADDR_Y_START = 8'h03;
  localparam logic [7:0] ADDR_Y_END = 8'h04;
  localparam logic [7:0] ADDR_Y_RELOAD = 8'h05;
  localparam logic [7:0] ADDR_OP_COUNT = 8'h06;
  localparam logic [7:0] ADDR_CONTROL = 8'h07;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ACC0 = 8'h09;
  localparam logic [7:0] ADDR_ACC4 = 8'h0D;
  localparam logic [7:0] ADDR_MEM_PTR = 8'h0E;
  localparam logic [7:0] ADDR_X_DATA = 8'h0F;
  localparam logic [7:0] ADDR_Y_DATA = 8'h10;
  // High address byte that marks a bank state change
  localparam logic [7:0] TRIGGER_HI = 8'h01;
  // Bank status codes
  localparam logic [1:0] BANK_EMPTY = 2'h0;
  localparam logic [1:0] BANK_READY = 2'h1;
  localparam logic [1:0] BANK_BUSY = 2'h2;
  localparam logic [1:0] BANK_DONE = 2'h3;
  // Field positions
  localparam int DATA_ST_LSB = 0;
  localparam int CALC_ST_LSB = 2;
  localparam int WSH_LSB = 0;
  localparam int RSH_LSB = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] NOISE_SEED = 8'h5C;
  localparam logic [7:0] NOISE_TAPS = 8'hB8;

  typedef struct packed {
    logic [IDX_W-1:0] x_start;
    logic [IDX_W-1:0] x_end;
    logic [IDX_W-1:0] x_reload;
    logic [IDX_W-1:0] y_start;
    logic [IDX_W-1:0] y_end;
    logic [IDX_W-1:0] y_reload;
    logic [7:0] op_count;
    logic [ACC_W-1:0] acc;
  } dbmac_bank_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dbmac_req_s;

  typedef enum logic [1:0] {CALC_IDLE, CALC_FETCH, CALC_MAC} dbmac_calc_e;
endpackage

// File: design/dbmac_ram.sv
// Sample memory: one write port, one read port with registered data.
// Assumes the host and the datapath never need the same port at once.
`timescale 1ns/100ps
module dbmac_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rd_data_next;

  // Storage, no reset on the array
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data registered
  always_comb begin
    rd_data_next = mem[rd_addr_i];
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= rd_data_next;
    end
  end
endmodule

// File: design/dbmac_index.sv
// Circular index counter: start, linear run to end, then reload.
// Assumes load and step are never high together.
`timescale 1ns/100ps
module dbmac_index #(
  parameter int IW = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic [IW-1:0] start_i,
  input wire logic [IW-1:0] end_i,
  input wire logic [IW-1:0] reload_i,
  output logic [IW-1:0] idx_o
);
  logic [IW-1:0] idx_next;

  // Next index
  always_comb begin
    idx_next = idx_o;
    if (load_i) begin
      idx_next = start_i;
    end else if (step_i) begin
      idx_next = (idx_o == end_i) ? reload_i : IW'(idx_o + 1'b1);
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_o <= '0;
    end else begin
      idx_o <= idx_next;
    end
  end

  a_index_reload: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    step_i && !load_i && idx_o == end_i |=> idx_o == $past(reload_i))
    else $error("index did not reload after end");
endmodule

// File: design/dbmac_top.sv
// Dual bank multiply-accumulate unit with host register port.
// Assumes one-cycle strobes, synchronous inputs, read data a cycle later.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
module dbmac_top #(
  parameter int IDX_W = dbmac_pkg::IDX_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire dbmac_pkg::dbmac_req_s host_req_i,
  output logic [7:0] rdata_o,
  output logic [1:0] exec_bank_state_o
);
  if (IDX_W != dbmac_pkg::IDX_W) begin : g_bad_idx
    $error("IDX_W must match the bank index field width");
  end

  //////////////////////////////////////////////////////////////////////////////
  // State
  dbmac_pkg::dbmac_bank_s bank_reg [2], bank_next [2];
  logic data_sel_reg, data_sel_next;
  logic [1:0] data_st_reg, data_st_next, calc_st_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [dbmac_pkg::ACC_W-1:0] stage_reg, stage_next;
  logic [IDX_W-1:0] mem_ptr_reg, mem_ptr_next, x_idx, y_idx;
  logic [7:0] noise_reg, noise_next;
  logic [7:0] rdata_next, lo;
  dbmac_pkg::dbmac_calc_e fsm_reg, fsm_next;
  logic [7:0] rem_reg, rem_next;
  logic start_calc, finish, mac_en, calc_sel;
  logic [dbmac_pkg::SMP_W-1:0] x_smp, y_smp;
  logic signed [2*dbmac_pkg::SMP_W-1:0] prod;
  logic [dbmac_pkg::SH_W-1:0] wsh, rsh;
  logic [dbmac_pkg::ACC_W-1:0] acc_sh, fill;
  logic [2:0] lane;
  logic wr, trig, is_acc, x_wr, y_wr;

  //////////////////////////////////////////////////////////////////////////////
  // Decode and datapath helpers
  assign lo = host_req_i.addr[7:0];
  assign wr = host_req_i.wr;
  assign trig = wr && host_req_i.addr[15:8] == dbmac_pkg::TRIGGER_HI
    && lo != dbmac_pkg::ADDR_STATUS;
  assign is_acc = lo >= dbmac_pkg::ADDR_ACC0 && lo <= dbmac_pkg::ADDR_ACC4;
  assign lane = 3'(lo - dbmac_pkg::ADDR_ACC0);
  assign x_wr = wr && lo == dbmac_pkg::ADDR_X_DATA;
  assign y_wr = wr && lo == dbmac_pkg::ADDR_Y_DATA;
  assign calc_sel = ~data_sel_reg;
  assign wsh = ctl_reg[dbmac_pkg::WSH_LSB +: dbmac_pkg::SH_W];
  assign rsh = ctl_reg[dbmac_pkg::RSH_LSB +: dbmac_pkg::SH_W];
  // Arithmetic shift keeps the two's complement sign
  assign acc_sh = dbmac_pkg::ACC_W'($signed(bank_reg[data_sel_reg].acc) >>> rsh);
  assign fill = noise_reg[0] ? dbmac_pkg::ACC_W'((41'h1 << wsh) - 41'h1) : '0;
  assign prod = $signed(x_smp) * $signed(y_smp);
  assign finish = fsm_reg == dbmac_pkg::CALC_FETCH && rem_reg == 8'h00;
  assign mac_en = fsm_reg == dbmac_pkg::CALC_MAC;

  //////////////////////////////////////////////////////////////////////////////
  // Sample memories and index counters
  dbmac_ram #(.AW(IDX_W), .DW(dbmac_pkg::SMP_W)) u_x_ram (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_en_i(x_wr),
    .wr_addr_i(mem_ptr_reg),
    .wr_data_i(host_req_i.wdata),
    .rd_addr_i(x_idx),
    .rd_data_o(x_smp)
  );
  dbmac_ram #(.AW(IDX_W), .DW(dbmac_pkg::SMP_W)) u_y_ram (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_en_i(y_wr),
    .wr_addr_i(mem_ptr_reg),
    .wr_data_i(host_req_i.wdata),
    .rd_addr_i(y_idx),
    .rd_data_o(y_smp)
  );
  dbmac_index #(.IW(IDX_W)) u_x_idx (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(start_calc),
    .step_i(mac_en),
    .start_i(bank_next[~data_sel_next].x_start),
    .end_i(bank_reg[calc_sel].x_end),
    .reload_i(bank_reg[calc_sel].x_reload),
    .idx_o(x_idx)
  );
  dbmac_index #(.IW(IDX_W)) u_y_idx (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(start_calc),
    .step_i(mac_en),
    .start_i(bank_next[~data_sel_next].y_start),
    .end_i(bank_reg[calc_sel].y_end),
    .reload_i(bank_reg[calc_sel].y_reload),
    .idx_o(y_idx)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Host writes, accumulation and bank state transitions
  always_comb begin
    bank_next = bank_reg;
    data_sel_next = data_sel_reg;
    data_st_next = data_st_reg;
    calc_st_next = exec_bank_state_o;
    ctl_next = ctl_reg;
    stage_next = stage_reg;
    mem_ptr_next = mem_ptr_reg;
    start_calc = 1'b0;
    noise_next = noise_reg[0] ? ((noise_reg >> 1) ^ dbmac_pkg::NOISE_TAPS) : (noise_reg >> 1);
    // Index, count and accumulator writes land in the data bank
    if (wr) begin
      if (lo == dbmac_pkg::ADDR_X_START) begin
        bank_next[data_sel_reg].x_start = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_X_END) begin
        bank_next[data_sel_reg].x_end = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_X_RELOAD) begin
        bank_next[data_sel_reg].x_reload = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_Y_START) begin
        bank_next[data_sel_reg].y_start = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_Y_END) begin
        bank_next[data_sel_reg].y_end = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_Y_RELOAD) begin
        bank_next[data_sel_reg].y_reload = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_OP_COUNT) begin
        bank_next[data_sel_reg].op_count = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_CONTROL) begin
        ctl_next = host_req_i.wdata;
      end else if (is_acc) begin
        stage_next[8*lane +: 8] = host_req_i.wdata;
        bank_next[data_sel_reg].acc = (stage_next << wsh) | fill;
      end else if (lo == dbmac_pkg::ADDR_MEM_PTR) begin
        mem_ptr_next = host_req_i.wdata;
      end else if (lo == dbmac_pkg::ADDR_Y_DATA) begin
        mem_ptr_next = IDX_W'(mem_ptr_reg + 1'b1);
      end
      // Writes other than to the status register signal a new definition, so a finished result is dropped
      if (lo != dbmac_pkg::ADDR_STATUS && data_st_reg == dbmac_pkg::BANK_DONE) begin
        data_st_next = dbmac_pkg::BANK_EMPTY;
      end
    end
    // Accumulate into the calculation bank
    if (mac_en) begin
      bank_next[calc_sel].acc = bank_reg[calc_sel].acc + dbmac_pkg::ACC_W'(prod);
    end
    // New calculation defined by the host
    if (trig) begin
      if (exec_bank_state_o == dbmac_pkg::BANK_EMPTY
          || exec_bank_state_o == dbmac_pkg::BANK_DONE) begin
        data_sel_next = ~data_sel_reg;
        data_st_next = exec_bank_state_o;
        calc_st_next = dbmac_pkg::BANK_BUSY;
        start_calc = 1'b1;
      end else begin
        data_st_next = dbmac_pkg::BANK_READY;
      end
    end
    // Calculation complete
    if (finish) begin
      if (data_st_next == dbmac_pkg::BANK_EMPTY || data_st_next == dbmac_pkg::BANK_READY) begin
        data_sel_next = ~data_sel_reg;
        calc_st_next = (data_st_next == dbmac_pkg::BANK_READY) ?
          dbmac_pkg::BANK_BUSY : dbmac_pkg::BANK_EMPTY;
        start_calc = data_st_next == dbmac_pkg::BANK_READY;
        data_st_next = dbmac_pkg::BANK_DONE;
      end else begin
        calc_st_next = dbmac_pkg::BANK_DONE;
      end
    end
  end

  // Bank state registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bank_reg[0] <= '0;
      bank_reg[1] <= '0;
      data_sel_reg <= 1'b0;
      data_st_reg <= dbmac_pkg::BANK_EMPTY;
      exec_bank_state_o <= dbmac_pkg::BANK_EMPTY;
      ctl_reg <= dbmac_pkg::CTL_RESET;
      stage_reg <= '0;
      mem_ptr_reg <= '0;
      noise_reg <= dbmac_pkg::NOISE_SEED;
    end else begin
      bank_reg <= bank_next;
      data_sel_reg <= data_sel_next;
      data_st_reg <= data_st_next;
      exec_bank_state_o <= calc_st_next;
      ctl_reg <= ctl_next;
      stage_reg <= stage_next;
      mem_ptr_reg <= mem_ptr_next;
      noise_reg <= noise_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Calculation sequencer: fetch samples, then multiply-accumulate
  always_comb begin
    fsm_next = fsm_reg;
    rem_next = rem_reg;
    case (fsm_reg)
      dbmac_pkg::CALC_IDLE: begin
        fsm_next = dbmac_pkg::CALC_IDLE;
      end
      dbmac_pkg::CALC_FETCH: begin
        fsm_next = (rem_reg == 8'h00) ? dbmac_pkg::CALC_IDLE : dbmac_pkg::CALC_MAC;
      end
      dbmac_pkg::CALC_MAC: begin
        rem_next = 8'(rem_reg - 1'b1);
        fsm_next = dbmac_pkg::CALC_FETCH;
      end
      default: begin
        fsm_next = dbmac_pkg::CALC_IDLE;
      end
    endcase
    if (start_calc) begin
      fsm_next = dbmac_pkg::CALC_FETCH;
      rem_next = bank_next[~data_sel_next].op_count;
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fsm_reg <= dbmac_pkg::CALC_IDLE;
      rem_reg <= 8'h00;
    end else begin
      fsm_reg <= fsm_next;
      rem_reg <= rem_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read data, one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (host_req_i.rd) begin
      if (lo == dbmac_pkg::ADDR_STATUS) begin
        rdata_next = {4'h0, exec_bank_state_o, data_st_reg};
      end else if (lo == dbmac_pkg::ADDR_CONTROL) begin
        rdata_next = ctl_reg;
      end else if (is_acc) begin
        rdata_next = acc_sh[8*lane +: 8];
      end else if (lo == dbmac_pkg::ADDR_OP_COUNT) begin
        rdata_next = bank_reg[data_sel_reg].op_count;
      end else if (lo == dbmac_pkg::ADDR_MEM_PTR) begin
        rdata_next = mem_ptr_reg;
      end
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] ops_seen, ops_want;
  // Counts products since the last start
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ops_seen <= 8'h00;
      ops_want <= 8'h00;
    end else if (start_calc) begin
      ops_seen <= 8'h00;
      ops_want <= rem_next;
    end else if (mac_en) begin
      ops_seen <= 8'(ops_seen + 1'b1);
    end
  end

  a_status_fields: assert property (
    host_req_i.rd && lo == dbmac_pkg::ADDR_STATUS |=>
    rdata_o[1:0] == $past(data_st_reg) && rdata_o[3:2] == $past(exec_bank_state_o))
    else $error("status read does not show bank states");
  a_swap_when_idle: assert property (
    trig && (exec_bank_state_o == dbmac_pkg::BANK_EMPTY
    || exec_bank_state_o == dbmac_pkg::BANK_DONE) |=>
    data_sel_reg != $past(data_sel_reg) && fsm_reg == dbmac_pkg::CALC_FETCH)
    else $error("idle unit did not swap on a new calculation");
  a_defer_when_busy: assert property (
    trig && exec_bank_state_o == dbmac_pkg::BANK_BUSY && !finish |=>
    data_st_reg == dbmac_pkg::BANK_READY && $stable(data_sel_reg))
    else $error("busy unit did not mark data ready");
  a_swap_on_finish: assert property (
    finish && data_st_reg == dbmac_pkg::BANK_EMPTY && !wr |=>
    data_st_reg == dbmac_pkg::BANK_DONE && data_sel_reg != $past(data_sel_reg)
    && exec_bank_state_o == dbmac_pkg::BANK_EMPTY)
    else $error("finished bank not handed to host");
  a_done_cleared: assert property (
    wr && !trig && !finish && lo != dbmac_pkg::ADDR_STATUS && data_st_reg == dbmac_pkg::BANK_DONE
    |=> data_st_reg == dbmac_pkg::BANK_EMPTY)
    else $error("host write left data bank done");
  a_top_byte_plain: assert property (
    host_req_i.rd && lo == dbmac_pkg::ADDR_ACC4 && rsh == 3'h0 |=>
    rdata_o == $past(bank_reg[data_sel_reg].acc[39:32]))
    else $error("unshifted top byte wrong");
  a_sign_fill: assert property (
    host_req_i.rd && lo == dbmac_pkg::ADDR_ACC4 && rsh == 3'h3 |=>
    rdata_o[7:5] == {3{$past(bank_reg[data_sel_reg].acc[39])}}
    && rdata_o[4:0] == $past(bank_reg[data_sel_reg].acc[39:35]))
    else $error("shift three top byte wrong");
  a_op_count: assert property (
    finish |-> ops_seen == ops_want)
    else $error("wrong number of products");
  a_idle_after_done: assert property (
    exec_bank_state_o == dbmac_pkg::BANK_DONE |-> fsm_reg == dbmac_pkg::CALC_IDLE)
    else $error("unit runs while calculation bank done");

  c_idle_swap: cover property (trig && exec_bank_state_o == dbmac_pkg::BANK_EMPTY);
  c_deferred: cover property (trig && exec_bank_state_o == dbmac_pkg::BANK_BUSY);
  c_chain: cover property (finish && data_st_reg == dbmac_pkg::BANK_READY);
  c_shift_read: cover property (host_req_i.rd && is_acc && rsh == 3'h7);
endmodule

// File: tb/dbmac_host_model.sv
// Host core model: drives the register port of the multiply-accumulate unit.
// Assumes one clock; strobes are single cycles launched just after a rising edge.
`timescale 1ns/100ps
module dbmac_host_model (
  input wire logic ref_clk_i,
  output dbmac_pkg::dbmac_req_s host_req_o,
  input wire logic [7:0] rdata_i
);
  // Port idles with no strobe from time zero
  initial begin
    host_req_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle; high address byte 01h only when a new calculation is meant
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    host_req_o <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    host_req_o <= '{addr: 16'h0000, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask

  // Read cycle; data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(posedge ref_clk_i);
    host_req_o <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    host_req_o <= '{addr: 16'h0000, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(negedge ref_clk_i);
    data = rdata_i;
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the dual bank multiply-accumulate unit.
// Assumes the host model above as the only register master.
`timescale 1ns/100ps
module tb_top;
  logic ref_clk_i;
  logic rst_i;
  dbmac_pkg::dbmac_req_s req;
  logic [7:0] rdata;
  logic [1:0] exec_st;
  int bad_count;
  int tests_run;
  int xs[4] = '{3, -5, 6, 1};
  int ys[4] = '{7, 2, -4, 9};

  dbmac_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_req_i(req),
    .rdata_o(rdata), .exec_bank_state_o(exec_st));
  dbmac_host_model host (.ref_clk_i(ref_clk_i), .host_req_o(req), .rdata_i(rdata));

  // 200 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared checking and closing
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic put_acc(input logic [39:0] v);
    for (int i = 0; i < 5; i++) begin
      host.wr({8'h00, 8'(dbmac_pkg::ADDR_ACC0 + i)}, v[8*i +: 8]);
    end
  endtask

  task automatic chk_acc(input logic [39:0] v);
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      host.rd({8'h00, 8'(dbmac_pkg::ADDR_ACC0 + i)}, d);
      check({32'h0, d}, {32'h0, v[8*i +: 8]});
    end
  endtask

  task automatic chk_stat(input logic [7:0] exp);
    logic [7:0] d;
    host.rd({8'h00, dbmac_pkg::ADDR_STATUS}, d);
    check({32'h0, d}, {32'h0, exp});
  endtask

  // Polls the calculation state until it matches, within a bound
  task automatic wait_exec(input logic [1:0] st);
    int n;
    n = 0;
    while (exec_st !== st && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (exec_st !== st) begin
      bad_count++;
      $display("ERROR %0t: calculation state stuck", $time);
      finish_test();
    end
  endtask

  // Reference sum: x runs 0..2 then reloads 1, y runs 0..3 then reloads 0
  function automatic logic [39:0] exp_mac(input int n, input logic [39:0] pre);
    int xi;
    int yi;
    logic signed [39:0] acc;
    acc = pre;
    xi = 0;
    yi = 0;
    for (int k = 0; k < n; k++) begin
      acc = acc + 40'(xs[xi] * ys[yi]);
      xi = (xi == 2) ? 1 : xi + 1;
      yi = (yi == 3) ? 0 : yi + 1;
    end
    return acc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_reset();
    check({38'h0, exec_st}, 40'h0);
    chk_stat(8'h00);
  endtask

  // Every read shift on a negative value, then a shifted write
  task automatic sc_shift();
    logic [39:0] v;
    logic [7:0] d;
    v = 40'hF012345678;
    put_acc(v);
    for (int s = 0; s < 8; s++) begin
      host.wr({8'h00, dbmac_pkg::ADDR_CONTROL}, {2'b00, 3'(s), 3'b000});
      chk_acc($signed(v) >>> s);
    end
    host.wr({8'h00, dbmac_pkg::ADDR_CONTROL}, 8'h24);
    put_acc(v);
    chk_acc(40'h0012345678);
    // Unshifted low byte: data nibble above four copies of one noise bit
    host.wr({8'h00, dbmac_pkg::ADDR_CONTROL}, 8'h04);
    host.rd({8'h00, dbmac_pkg::ADDR_ACC0}, d);
    check({32'h0, d}, {32'h0, 4'h8, {4{d[0]}}});
  endtask

  // Circular indexing run; result swapped back to the host side
  task automatic sc_calc();
    logic [7:0] ix[6] = '{8'h00, 8'h02, 8'h01, 8'h00, 8'h03, 8'h00};
    host.wr({8'h00, dbmac_pkg::ADDR_CONTROL}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      host.wr({8'h00, 8'(i)}, ix[i]);
    end
    host.wr({8'h00, dbmac_pkg::ADDR_MEM_PTR}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr({8'h00, dbmac_pkg::ADDR_X_DATA}, 8'(xs[i]));
      host.wr({8'h00, dbmac_pkg::ADDR_Y_DATA}, 8'(ys[i]));
    end
    put_acc(40'h0000001000);
    host.wr({dbmac_pkg::TRIGGER_HI, dbmac_pkg::ADDR_OP_COUNT}, 8'h03);
    @(negedge ref_clk_i);
    check({38'h0, exec_st}, {38'h0, dbmac_pkg::BANK_BUSY});
    wait_exec(dbmac_pkg::BANK_EMPTY);
    chk_stat(8'h03);
    chk_acc(exp_mac(3, 40'h0000001000));
    host.wr({8'h00, dbmac_pkg::ADDR_STATUS}, 8'h00);
    chk_stat(8'h03);
    host.wr({8'h00, dbmac_pkg::ADDR_CONTROL}, 8'h00);
    chk_stat(8'h00);
  endtask

  // Second calculation defined while the first still runs
  task automatic sc_deferred();
    put_acc(40'h0);
    host.wr({dbmac_pkg::TRIGGER_HI, dbmac_pkg::ADDR_OP_COUNT}, 8'h04);
    host.wr({dbmac_pkg::TRIGGER_HI, dbmac_pkg::ADDR_OP_COUNT}, 8'h01);
    chk_stat(8'h09);
    wait_exec(dbmac_pkg::BANK_DONE);
    chk_stat(8'h0F);
    chk_acc(exp_mac(4, 40'h0));
  endtask

  // New calculation while the calculation bank is done: immediate swap
  task automatic sc_done_swap();
    host.wr({dbmac_pkg::TRIGGER_HI, dbmac_pkg::ADDR_OP_COUNT}, 8'h02);
    chk_stat(8'h0B);
    wait_exec(dbmac_pkg::BANK_DONE);
    chk_stat(8'h0F);
    chk_acc(exp_mac(1, 40'h0));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    sc_reset();
    sc_shift();
    sc_calc();
    sc_deferred();
    sc_done_swap();
    finish_test();
  end
endmodule
